// ===== bench/jrx_framer_model.sv
`default_nettype none
module jrx_framer_model (
  // clock
  input  wire logic             core_clk,
  // lane characters toward the receiver
  output var jrx_pkg::jrx_char_t rx_char
);
  timeunit 1ns;
  timeprecision 1ns;

  // lane starts released
  initial rx_char = '0;

  // n copies of one character, changed just after an edge
  task automatic send(input logic k, input logic [7:0] v, input int n);
    repeat (n) begin
      @(posedge core_clk);
      rx_char <= '{1'b1, k, 1'b0, 1'b0, v};
    end
  endtask

  // release: octet inverted so a stale value never looks fresh
  task automatic idle();
    @(posedge core_clk);
    rx_char <= '{1'b0, 1'b0, 1'b0, 1'b0, ~rx_char.octet};
  endtask

  // sync run, then alignment sequence; it opens with /R/, a /Q/ straight
  // after /K/ would read as a bad follower; octet 1 and checksum given
  task automatic start_up(input logic [7:0] c1, input logic [7:0] cks);
    send(1'b1, jrx_pkg::K_K, 4);
    send(1'b1, jrx_pkg::K_R, 1);
    send(1'b1, jrx_pkg::K_Q, 1);
    send(1'b0, 8'h00, 1);
    send(1'b0, c1, 1);
    send(1'b0, 8'h00, 11);
    send(1'b0, cks, 1);
    send(1'b1, jrx_pkg::K_A, 4);
    idle();
  endtask

  // n data characters carrying error flags
  task automatic err(input logic nit, input logic dsp, input int n);
    repeat (n) begin
      @(posedge core_clk);
      rx_char <= '{1'b1, 1'b0, nit, dsp, 8'hFF};
    end
  endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic               core_clk;
  logic               reset;
  logic [11:0]        reg_addr;
  logic [7:0]         reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [7:0]         reg_rdata;
  jrx_pkg::jrx_char_t  rx_char;
  jrx_pkg::jrx_octet_t user_data;
  logic               sync_request_out;
  logic               irq;
  logic [7:0]         got_q[$]; // user octets seen
  int                 n_fail;
  int                 compares;

  jrx_link_rx_control uut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_char(rx_char), .user_data(user_data), .sync_request_out(sync_request_out),
    .irq(irq));

  jrx_framer_model fm (.core_clk(core_clk), .rx_char(rx_char));

  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // collect every user octet
  always @(posedge core_clk) begin
    if (user_data.valid === 1'b1) got_q.push_back(user_data.octet);
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // configuration only changes under soft reset
  task automatic cfg(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] c2);
    wr(jrx_pkg::ADDR_CTRL0, c0 | 8'h08);
    wr(jrx_pkg::ADDR_CTRL1, c1);
    wr(jrx_pkg::ADDR_CTRL2, c2);
    wr(jrx_pkg::ADDR_CTRL0, c0);
  endtask

  task automatic t_reset_vals();
    rd(jrx_pkg::ADDR_CTRL0, 8'h01);
    rd(jrx_pkg::ADDR_CTRL1, 8'h14);
    rd(jrx_pkg::ADDR_CTRL2, 8'h00);
    wr(jrx_pkg::ADDR_ILS, 8'hFF);
    rd(jrx_pkg::ADDR_ILS, 8'h00);
    wr(12'h474, 8'hFF);
    rd(12'h474, 8'h00);
    chk({7'h00, sync_request_out}, 8'h01);
    chk({7'h00, irq}, 8'h00);
  endtask

  // full start-up, forced request on top of a live link
  task automatic t_link_up();
    cfg(8'h01, 8'h14, 8'h00);
    fm.start_up(8'hFF, 8'h0F);
    repeat (3) @(posedge core_clk);
    rd(jrx_pkg::ADDR_ILS, 8'h01);
    rd(jrx_pkg::ADDR_CKS, 8'h01);
    chk({7'h00, sync_request_out}, 8'h00);
    rd(jrx_pkg::ADDR_IRQ_ST, 8'h01);
    rd(jrx_pkg::ADDR_IRQ_ST, 8'h00);
    wr(jrx_pkg::ADDR_CTRL0, 8'h05);
    chk({7'h00, sync_request_out}, 8'h01);
    wr(jrx_pkg::ADDR_CTRL0, 8'h01);
    chk({7'h00, sync_request_out}, 8'h00);
  endtask

  // K followed by a data octet drops the link, interrupt unmasked
  task automatic t_resync();
    wr(jrx_pkg::ADDR_IRQ_MSK, 8'h02);
    fm.send(1'b1, jrx_pkg::K_K, 1);
    fm.send(1'b0, 8'h55, 1);
    fm.idle();
    repeat (3) @(posedge core_clk);
    chk({7'h00, sync_request_out}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rd(jrx_pkg::ADDR_ILS, 8'h00);
    rd(jrx_pkg::ADDR_IRQ_ST, 8'h02);
    chk({7'h00, irq}, 8'h00);
    wr(jrx_pkg::ADDR_IRQ_MSK, 8'h00);
  endtask

  // omission mode with offset: octets 0, 1 untouched, octet 2 descrambled;
  // post-sync select off, else data right after /K/ is a bad follower
  task automatic t_omit_offset();
    cfg(8'h01, 8'hFA, 8'h00);
    rd(jrx_pkg::ADDR_CTRL1, 8'h1A);
    got_q.delete();
    fm.send(1'b1, jrx_pkg::K_K, 4);
    fm.send(1'b0, 8'hC0, 1);
    fm.send(1'b0, 8'h22, 1);
    fm.send(1'b0, 8'h00, 1);
    fm.idle();
    repeat (4) @(posedge core_clk);
    chk(8'(got_q.size()), 8'h03);
    chk(got_q[0], 8'hC0);
    chk(got_q[1], 8'h22);
    chk(got_q[2], 8'h80);
  endtask

  // endless alignment keeps the flag low; soft reset brings back request
  // packed-octet sum 0xFF misses the field sum 0x0F sent as checksum
  task automatic t_test_mode();
    cfg(8'h01, 8'h15, 8'h80);
    fm.start_up(8'hFF, 8'h0F);
    repeat (3) @(posedge core_clk);
    rd(jrx_pkg::ADDR_ILS, 8'h00);
    rd(jrx_pkg::ADDR_CKS, 8'h00);
    chk({7'h00, sync_request_out}, 8'h00);
    wr(jrx_pkg::ADDR_CTRL0, 8'h09);
    // soft reset acts one edge after the write lands
    @(posedge core_clk);
    #1;
    chk({7'h00, sync_request_out}, 8'h01);
    rd(jrx_pkg::ADDR_CTRL0, 8'h09);
    cfg(8'h01, 8'h14, 8'h00);
  endtask

  // /A/ at the last frame position over all-zero data, which descrambles to itself
  task automatic t_end_char(input logic [7:0] c0, input logic [7:0] exp);
    cfg(c0, 8'h1A, 8'h00);
    got_q.delete();
    fm.send(1'b1, jrx_pkg::K_K, 4);
    fm.send(1'b0, 8'h00, 3);
    fm.send(1'b1, jrx_pkg::K_A, 1);
    fm.idle();
    repeat (4) @(posedge core_clk);
    chk(8'(got_q.size()), 8'h04);
    chk(got_q[3], exp);
  endtask

  // errored octet replaced; masked disparity ignored; 8 plain ones resync
  task automatic t_errors();
    cfg(8'h01, 8'h1A, 8'h00);
    got_q.delete();
    fm.send(1'b1, jrx_pkg::K_K, 4);
    fm.send(1'b0, 8'h5A, 1);
    fm.err(1'b1, 1'b1, 8);
    fm.idle();
    repeat (4) @(posedge core_clk);
    chk(got_q[1], 8'h5A);
    chk({7'h00, sync_request_out}, 8'h00);
    rd(jrx_pkg::ADDR_IRQ_ST, 8'h00);
    fm.err(1'b0, 1'b1, 7);
    fm.idle();
    repeat (2) @(posedge core_clk);
    chk({7'h00, sync_request_out}, 8'h00);
    fm.err(1'b0, 1'b1, 1);
    fm.idle();
    repeat (2) @(posedge core_clk);
    chk({7'h00, sync_request_out}, 8'h01);
    rd(jrx_pkg::ADDR_IRQ_ST, 8'h0A);
  endtask

  task automatic give_verdict();
    $display("n_fail %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial begin
    n_fail = 0;
    compares = 0;
    reset = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    t_reset_vals();
    t_link_up();
    t_resync();
    t_omit_offset();
    t_end_char(8'h01, 8'h00);
    t_end_char(8'h81, 8'h7C);
    t_end_char(8'h41, 8'h7C);
    t_errors();
    t_test_mode();
    give_verdict();
  end

  // watchdog: run needs a few hundred cycles
  initial begin
    #1000000;
    n_fail++;
    $display("ERROR %0t: timeout", $time);
    give_verdict();
  end
endmodule
`default_nettype wire

// ===== rtl/jrx_checksum.sv
`default_nettype none
module jrx_checksum (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // configuration octets
  input  wire logic       clr,
  input  wire logic       valid,
  input  wire logic [3:0] idx,
  input  wire logic [7:0] octet,
  input  wire logic       method,
  // result
  output logic            done,
  output logic            ok
);
  typedef struct packed {
    logic [7:0] sum;
    logic       done;
    logic       ok;
  } jrx_cks_state_t;

  jrx_cks_state_t s_q;  // registered state
  jrx_cks_state_t s_d;  // next state

  // sum of the separate fields packed in one octet
  function automatic logic [7:0] field_sum(input logic [3:0] i, input logic [7:0] o);
    case (i)
      4'h1:                field_sum = {4'h0, o[3:0]};
      4'h2, 4'h5:          field_sum = {3'h0, o[4:0]};
      4'h3, 4'hA:          field_sum = {7'h00, o[7]} + {3'h0, o[4:0]};
      4'h7:                field_sum = {6'h00, o[7:6]} + {3'h0, o[4:0]};
      4'h8, 4'h9:          field_sum = {5'h00, o[7:5]} + {3'h0, o[4:0]};
      4'hB, 4'hC:          field_sum = 8'h00;
      default:             field_sum = o;
    endcase
  endfunction

  // accumulate octets 0..12, compare with the last one
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (valid && idx == jrx_pkg::CFG_LAST) begin
      s_d.done = 1'b1;
      s_d.ok   = (s_q.sum == octet);
    end else if (valid) begin
      s_d.sum = s_q.sum + (method ? octet : field_sum(idx, octet));
    end
    if (clr) begin
      s_d = '0;
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign ok   = s_q.ok;
endmodule
`default_nettype wire

// ===== rtl/jrx_descrambler.sv
`default_nettype none
module jrx_descrambler (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                reset,
  // control
  input  wire logic                clr,
  input  wire logic                bypass,
  // octets
  input  wire jrx_pkg::jrx_octet_t din,
  output jrx_pkg::jrx_octet_t      dout
);
  // lfsr holds the last 15 received scrambled bits
  typedef struct packed {
    logic [14:0]         sr;
    jrx_pkg::jrx_octet_t out;
  } jrx_dsc_state_t;

  jrx_dsc_state_t s_q;  // registered state
  jrx_dsc_state_t s_d;  // next state

  // self-synchronous descramble, msb first
  always_comb begin
    s_d = s_q;
    s_d.out.valid = din.valid;
    if (din.valid) begin
      for (int i = 7; i >= 0; i--) begin
        s_d.out.octet[i] = bypass ? din.octet[i] : (din.octet[i] ^ s_d.sr[13] ^ s_d.sr[14]);
        s_d.sr = {s_d.sr[13:0], din.octet[i]};
      end
    end
    if (clr) begin
      s_d = '0;
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.out;
endmodule
`default_nettype wire

// ===== rtl/jrx_link_rx_control.sv
// Operation
// - lane 0 sync flag, read only, resets 0
// - bit 7 zero substitutes end characters
// - bit 6 one disables end character replacement
// - soft reset returns receiver to power-on
// - forced request bit asserts sync request
// - replace errored frames, enabled after reset
// - table error masks concurrent disparity error
// - descrambling starts octet 2 or 0
// - mode 0 resyncs on enough disparity errors
// - mode 1 resyncs on bad follower of K
// - omission mode goes straight to data
// - checksum by fields or by octets
// - test mode repeats alignment sequence forever
//
// The address-and-strobe port was decided locally.
`default_nettype none
module jrx_link_rx_control #(
  parameter int FRAME_OCTETS = 4,  // octets per frame
  parameter int ERR_LIMIT    = 8   // disparity errors that force resync
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                reset,
  // register port
  input  wire logic [11:0]         reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [7:0]               reg_rdata,
  // lane 0 decoded characters
  input  wire jrx_pkg::jrx_char_t  rx_char,
  // user data and link control
  output jrx_pkg::jrx_octet_t      user_data,
  output logic                     sync_request_out,
  output logic                     irq
);
  localparam int FO_W  = $clog2(FRAME_OCTETS + 1);  // frame position width
  localparam int ERR_W = $clog2(ERR_LIMIT + 1);     // error count width

  // refuse sizes the counters cannot hold
  if (FRAME_OCTETS < 1 || FRAME_OCTETS > 256) begin : g_fo_chk
    $error("FRAME_OCTETS out of range");
  end
  if (ERR_LIMIT < 1 || ERR_LIMIT > 255) begin : g_err_chk
    $error("ERR_LIMIT out of range");
  end

  // receiver state that soft reset clears
  typedef struct packed {
    jrx_pkg::jrx_lane_st_t st;
    logic [2:0]            k_cnt;
    logic [2:0]            mf_cnt;
    logic [ERR_W-1:0]      err_cnt;
    logic                  prev_k;
    logic                  ils;
    logic                  cks_ok;
    logic                  started;
    logic [FO_W-1:0]       frm_pos;
    logic [7:0]            last_oct;
    logic                  cfg_on;
    logic [3:0]            cfg_idx;
    logic [1:0]            dat_cnt;
    jrx_pkg::jrx_octet_t   rep;
  } jrx_lane_t;

  // whole block state
  typedef struct packed {
    logic [7:0]               ctrl0;
    logic [7:0]               ctrl1;
    logic [7:0]               ctrl2;
    logic [7:0]               rdata;
    logic [jrx_pkg::EV_W-1:0] irq_st;
    logic [jrx_pkg::EV_W-1:0] irq_msk;
    jrx_lane_t                ln;
  } jrx_rx_state_t;

  localparam jrx_lane_t LANE_RST = '{st: jrx_pkg::ST_CGS, default: '0};

  jrx_rx_state_t s_q;  // registered state
  jrx_rx_state_t s_d;  // next state

  // decoded views of the control registers
  logic subst_dis, repl_dis, soft_rst, force_sync, frm_repl;
  logic qual_rd, dsc_ofs, post_cgs_behaviour_select, alignment_sequence_omit, cks_meth, test_mode;
  assign subst_dis  = s_q.ctrl0[jrx_pkg::C0_SUBST_DIS];
  assign repl_dis   = s_q.ctrl0[jrx_pkg::C0_REPL_DIS];
  assign soft_rst   = s_q.ctrl0[jrx_pkg::C0_SOFT_RST];
  assign force_sync = s_q.ctrl0[jrx_pkg::C0_FORCE_SYNC];
  assign frm_repl   = s_q.ctrl0[jrx_pkg::C0_FRM_REPL];
  assign qual_rd    = s_q.ctrl1[jrx_pkg::C1_QUAL_RD];
  assign dsc_ofs    = s_q.ctrl1[jrx_pkg::C1_DSC_OFS];
  assign post_cgs_behaviour_select    = s_q.ctrl1[jrx_pkg::C1_POST_CGS_BEHAVIOUR_SELECT];
  assign alignment_sequence_omit    = s_q.ctrl1[jrx_pkg::C1_ALIGNMENT_SEQUENCE_OMIT];
  assign cks_meth   = s_q.ctrl1[jrx_pkg::C1_CKS_METH];
  assign test_mode  = s_q.ctrl2[jrx_pkg::C2_TEST_MODE];

  // character classes of the current input
  logic is_kk;     // code group sync character
  logic disp_q;    // disparity error after qualification
  logic char_err;  // any error on this character
  logic bad_seq;   // K followed by other than R or K
  logic frm_end;   // last octet of a frame
  logic end_char;  // A or F at a frame end
  always_comb begin
    is_kk    = rx_char.valid && rx_char.is_k && rx_char.octet == jrx_pkg::K_K;
    disp_q   = rx_char.valid && rx_char.disp_err && !(qual_rd && rx_char.nit_err);
    char_err = disp_q || (rx_char.valid && rx_char.nit_err);
    bad_seq  = s_q.ln.prev_k && rx_char.valid
               && !(rx_char.is_k && (rx_char.octet == jrx_pkg::K_R || is_kk));
    frm_end  = s_q.ln.frm_pos == FO_W'(FRAME_OCTETS - 1);
    end_char = rx_char.is_k && frm_end
               && (rx_char.octet == jrx_pkg::K_A || rx_char.octet == jrx_pkg::K_F);
  end

  // checksum engine result
  logic cks_done, cks_ok;
  logic cfg_vld;  // a configuration octet this cycle
  assign cfg_vld = s_q.ln.cfg_on && rx_char.valid && !rx_char.is_k;

  // descrambler bypass
  logic dsc_bypass;  // count runs one ahead of the replace stage, hence <=
  assign dsc_bypass = dsc_ofs && s_q.ln.dat_cnt <= jrx_pkg::DSC_SKIP;

  jrx_checksum u_cks (
    .core_clk (core_clk),
    .reset    (reset),
    .clr      (soft_rst || !s_q.ln.cfg_on),
    .valid    (cfg_vld),
    .idx      (s_q.ln.cfg_idx),
    .octet    (rx_char.octet),
    .method   (cks_meth),
    .done     (cks_done),
    .ok       (cks_ok)
  );

  jrx_descrambler u_dsc (
    .core_clk (core_clk),
    .reset    (reset),
    .clr      (soft_rst || s_q.ln.st != jrx_pkg::ST_DATA),
    .bypass   (dsc_bypass),
    .din      (s_q.ln.rep),
    .dout     (user_data)
  );

  // next-state logic: registers, lane sequence, events
  logic [jrx_pkg::EV_W-1:0] ev;  // events this cycle
  always_comb begin
    s_d = s_q;
    ev  = '0;
    s_d.ln.rep.valid = 1'b0;

    // register writes, reserved bits stay zero
    if (reg_wr) begin
      case (reg_addr)
        jrx_pkg::ADDR_CTRL0:   s_d.ctrl0 = reg_wdata & jrx_pkg::C0_WMASK;
        jrx_pkg::ADDR_CTRL1:   s_d.ctrl1 = reg_wdata & jrx_pkg::C1_WMASK;
        jrx_pkg::ADDR_CTRL2:   s_d.ctrl2 = reg_wdata & jrx_pkg::C2_WMASK;
        jrx_pkg::ADDR_IRQ_MSK: s_d.irq_msk = reg_wdata[jrx_pkg::EV_W-1:0];
        default: ;
      endcase
    end

    // read data stands in the following cycle only
    s_d.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        jrx_pkg::ADDR_CKS:     s_d.rdata = {7'h00, s_q.ln.cks_ok};
        jrx_pkg::ADDR_ILS:     s_d.rdata = {7'h00, s_q.ln.ils};
        jrx_pkg::ADDR_CTRL0:   s_d.rdata = s_q.ctrl0;
        jrx_pkg::ADDR_CTRL1:   s_d.rdata = s_q.ctrl1;
        jrx_pkg::ADDR_CTRL2:   s_d.rdata = s_q.ctrl2;
        jrx_pkg::ADDR_IRQ_ST:  s_d.rdata = {4'h0, s_q.irq_st};
        jrx_pkg::ADDR_IRQ_MSK: s_d.rdata = {4'h0, s_q.irq_msk};
        default:               s_d.rdata = 8'h00;
      endcase
    end

    // remember a /K/ for the follower check
    if (rx_char.valid) begin
      s_d.ln.prev_k = is_kk;
    end

    case (s_q.ln.st)
      // count consecutive /K/ for code group sync
      jrx_pkg::ST_CGS: begin
        if (rx_char.valid) begin
          s_d.ln.k_cnt = is_kk ? s_q.ln.k_cnt + 3'h1 : 3'h0;
        end
        if (is_kk && s_q.ln.k_cnt == jrx_pkg::CGS_K_COUNT - 3'h1) begin
          s_d.ln.k_cnt   = 3'h0;
          s_d.ln.err_cnt = '0;
          s_d.ln.mf_cnt  = 3'h0;
          s_d.ln.st = alignment_sequence_omit ? jrx_pkg::ST_DATA : jrx_pkg::ST_ILAS;
        end
      end
      // alignment sequence: config after /Q/, ends on the last /A/
      jrx_pkg::ST_ILAS: begin
        if (rx_char.valid && rx_char.is_k && rx_char.octet == jrx_pkg::K_Q) begin
          s_d.ln.cfg_on  = 1'b1;
          s_d.ln.cfg_idx = 4'h0;
        end else if (cfg_vld) begin
          s_d.ln.cfg_idx = s_q.ln.cfg_idx + 4'h1;
          s_d.ln.cfg_on  = s_q.ln.cfg_idx != jrx_pkg::CFG_LAST;
        end
        if (rx_char.valid && rx_char.is_k && rx_char.octet == jrx_pkg::K_A) begin
          s_d.ln.mf_cnt = s_q.ln.mf_cnt + 3'h1;
          if (s_q.ln.mf_cnt == jrx_pkg::ILAS_MF_COUNT - 3'h1) begin
            s_d.ln.mf_cnt = 3'h0;
            if (!test_mode) begin
              s_d.ln.st  = jrx_pkg::ST_DATA;
              s_d.ln.ils = 1'b1;
              ev[jrx_pkg::EV_ILS_UP] = 1'b1;
            end
          end
        end
      end
      // user data: replacement stage feeding the descrambler
      jrx_pkg::ST_DATA: begin
        if (rx_char.valid && (s_q.ln.started || !is_kk)) begin
          s_d.ln.started   = 1'b1;
          s_d.ln.rep.valid = 1'b1;
          s_d.ln.rep.octet = rx_char.octet;
          if (char_err && frm_repl) begin
            s_d.ln.rep.octet = s_q.ln.last_oct;
          end else if (end_char && !subst_dis && !repl_dis) begin
            s_d.ln.rep.octet = s_q.ln.last_oct;
          end
          s_d.ln.last_oct = s_d.ln.rep.octet;
          s_d.ln.frm_pos  = frm_end ? '0 : s_q.ln.frm_pos + FO_W'(1);
          if (s_q.ln.dat_cnt <= jrx_pkg::DSC_SKIP) begin
            s_d.ln.dat_cnt = s_q.ln.dat_cnt + 2'h1;
          end
        end
      end
      default: s_d.ln = LANE_RST;
    endcase

    // checksum result latched per alignment sequence
    if (cks_done) begin
      s_d.ln.cks_ok = cks_ok;
      ev[jrx_pkg::EV_CKS_BAD] = !cks_ok;
    end

    // disparity errors counted only in standard mode
    ev[jrx_pkg::EV_DISP] = disp_q;
    if (s_q.ln.st != jrx_pkg::ST_CGS && !post_cgs_behaviour_select && disp_q) begin
      s_d.ln.err_cnt = s_q.ln.err_cnt + ERR_W'(1);
    end

    // loss of lane sync sends the lane back to code group sync
    if (s_q.ln.st != jrx_pkg::ST_CGS) begin
      if ((post_cgs_behaviour_select && bad_seq)
          || (!post_cgs_behaviour_select && s_d.ln.err_cnt == ERR_W'(ERR_LIMIT))) begin
        s_d.ln = LANE_RST;
        ev[jrx_pkg::EV_SYNC_LOST] = 1'b1;
      end
    end

    // soft reset holds the lane, checksum and descrambler at power-on values; control, interrupt status and mask registers keep theirs
    if (soft_rst) begin
      s_d.ln = LANE_RST;
      ev = '0;
    end

    // sticky status: a read clears, a new event wins
    if (reg_rd && reg_addr == jrx_pkg::ADDR_IRQ_ST) begin
      s_d.irq_st = ev;
    end else begin
      s_d.irq_st = s_q.irq_st | ev;
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_q.ctrl0   <= jrx_pkg::CTRL0_RST;
      s_q.ctrl1   <= jrx_pkg::CTRL1_RST;
      s_q.ctrl2   <= jrx_pkg::CTRL2_RST;
      s_q.rdata   <= 8'h00;
      s_q.irq_st  <= '0;
      s_q.irq_msk <= '0;
      s_q.ln      <= LANE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs; request is a level, any cause holds it
  assign reg_rdata        = s_q.rdata;
  assign sync_request_out = force_sync || s_q.ln.st == jrx_pkg::ST_CGS;
  assign irq              = |(s_q.irq_st & s_q.irq_msk);

  // forced request always reaches the pin
  force_sync_a: assert property (@(posedge core_clk) disable iff (reset)
    force_sync |-> sync_request_out)
    else $error("forced sync request not on output");

  // flag only while the lane carries data
  ils_state_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.ln.ils |-> s_q.ln.st == jrx_pkg::ST_DATA && !alignment_sequence_omit)
    else $error("lane sync flag set outside data");

  // soft reset clears the lane within one edge
  soft_reset_a: assert property (@(posedge core_clk) disable iff (reset)
    soft_rst |=> (!s_q.ln.ils && s_q.ln.st == jrx_pkg::ST_CGS && !user_data.valid) [*2])
    else $error("soft reset did not clear receiver");

  // substitution disable (bit 7) keeps end characters as received
  end_subst_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.ln.st == jrx_pkg::ST_DATA && s_q.ln.started && rx_char.valid && end_char
    && subst_dis && !char_err && !soft_rst && !(post_cgs_behaviour_select && bad_seq)
    |=> s_q.ln.rep.octet == $past(rx_char.octet))
    else $error("end character substituted while disabled");

  end_repl_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.ln.st == jrx_pkg::ST_DATA && s_q.ln.started && rx_char.valid && end_char
    && !subst_dis && !repl_dis && !char_err && !soft_rst && !(post_cgs_behaviour_select && bad_seq)
    |=> s_q.ln.rep.octet == $past(s_q.ln.last_oct))
    else $error("end character not replaced");

  // errored octet repeats the previous good octet
  frame_repl_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.ln.st == jrx_pkg::ST_DATA && s_q.ln.started && char_err && frm_repl
    && !soft_rst && !(post_cgs_behaviour_select && bad_seq) && s_q.ln.err_cnt < ERR_W'(ERR_LIMIT - 1)
    |=> s_q.ln.rep.valid && s_q.ln.rep.octet == $past(s_q.ln.last_oct))
    else $error("errored octet passed through");

  // qualified disparity error leaves the count alone
  disp_qual_a: assert property (@(posedge core_clk) disable iff (reset)
    qual_rd && rx_char.valid && rx_char.nit_err && !soft_rst
    && s_q.ln.st == jrx_pkg::ST_DATA |=> $stable(s_q.ln.err_cnt) || s_q.ln.err_cnt == '0)
    else $error("masked disparity error counted");

  // bad follower of /K/ forces resync next edge
  k_follow_a: assert property (@(posedge core_clk) disable iff (reset)
    post_cgs_behaviour_select && bad_seq && s_q.ln.st != jrx_pkg::ST_CGS
    |=> s_q.ln.st == jrx_pkg::ST_CGS && sync_request_out)
    else $error("bad follower did not resync");

  // omission mode never enters the alignment state
  alignment_sequence_omit_a: assert property (@(posedge core_clk) disable iff (reset)
    alignment_sequence_omit && s_q.ln.st == jrx_pkg::ST_CGS ##1 s_q.ln.st != jrx_pkg::ST_CGS
    |-> s_q.ln.st == jrx_pkg::ST_DATA)
    else $error("alignment sequence entered in omission mode");

  // test mode keeps repeating the alignment sequence
  test_mode_a: assert property (@(posedge core_clk) disable iff (reset)
    test_mode && s_q.ln.st == jrx_pkg::ST_ILAS |=> s_q.ln.st != jrx_pkg::ST_DATA)
    else $error("test mode left alignment sequence");
endmodule
`default_nettype wire

// ===== rtl/jrx_pkg.sv
`default_nettype none
package jrx_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_CKS     = 12'h472;
  localparam logic [11:0] ADDR_ILS     = 12'h473;
  localparam logic [11:0] ADDR_CTRL0   = 12'h475;
  localparam logic [11:0] ADDR_CTRL1   = 12'h476;
  localparam logic [11:0] ADDR_CTRL2   = 12'h477;
  localparam logic [11:0] ADDR_IRQ_ST  = 12'h480;
  localparam logic [11:0] ADDR_IRQ_MSK = 12'h481;
  // control 0 fields
  localparam int C0_SUBST_DIS  = 7;
  localparam int C0_REPL_DIS   = 6;
  localparam int C0_SOFT_RST   = 3;
  localparam int C0_FORCE_SYNC = 2;
  localparam int C0_FRM_REPL   = 0;
  localparam logic [7:0] CTRL0_RST = 8'h01;
  localparam logic [7:0] C0_WMASK  = 8'hCD;
  // control 1 fields
  localparam int C1_QUAL_RD  = 4;
  localparam int C1_DSC_OFS  = 3;
  localparam int C1_POST_CGS_BEHAVIOUR_SELECT  = 2;
  localparam int C1_ALIGNMENT_SEQUENCE_OMIT  = 1;
  localparam int C1_CKS_METH = 0;
  localparam logic [7:0] CTRL1_RST = 8'h14;
  localparam logic [7:0] C1_WMASK  = 8'h1F;
  // control 2 fields
  localparam int C2_TEST_MODE = 7;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] C2_WMASK  = 8'h80;
  // status bit positions
  localparam int ILS_LANE0 = 0;
  localparam int CKS_LANE0 = 0;
  // interrupt events
  localparam int EV_ILS_UP    = 0;
  localparam int EV_SYNC_LOST = 1;
  localparam int EV_CKS_BAD   = 2;
  localparam int EV_DISP      = 3;
  localparam int EV_W         = 4;
  // control characters (k flag set)
  localparam logic [7:0] K_R = 8'h1C;
  localparam logic [7:0] K_A = 8'h7C;
  localparam logic [7:0] K_Q = 8'h9C;
  localparam logic [7:0] K_K = 8'hBC;
  localparam logic [7:0] K_F = 8'hFC;
  // sequence counts
  localparam logic [2:0] CGS_K_COUNT   = 3'h4;
  localparam logic [2:0] ILAS_MF_COUNT = 3'h4;
  localparam logic [3:0] CFG_LAST      = 4'hD;
  localparam logic [1:0] DSC_SKIP      = 2'h2;
  // lane state
  typedef enum logic [2:0] {
    ST_CGS  = 3'b001,
    ST_ILAS = 3'b010,
    ST_DATA = 3'b100
  } jrx_lane_st_t;
  // decoded character from the deserializer
  typedef struct packed {
    logic       valid;
    logic       is_k;
    logic       nit_err;
    logic       disp_err;
    logic [7:0] octet;
  } jrx_char_t;
  // one user octet
  typedef struct packed {
    logic       valid;
    logic [7:0] octet;
  } jrx_octet_t;
endpackage
`default_nettype wire
